// File: rpdb_core.sv
// Purpose: Pointer and access control for the radio packet data buffer.
// Assumes: Host port and radio datapath are on clk_i; one memory port shared.
// Notes: Host access wins over radio for the single port, radio is told to wait.
// Functional notes
// - 256-byte memory, readable and writable in every mode except sleep.
// - Received bytes stored from receive base; write pointer holds last written offset.
// - Status query returns start offset and length of last received packet.
// - Single reception reloads write pointer from receive base on each receive entry.
// - Continuous reception keeps advancing pointer; status reports only latest packet.
// - Transmit entry loads fetch pointer from transmit base; advances per byte.
// - Fetching stops once count sent equals configured payload length.
// - Set-bases command writes both bases; both default to offset zero.
// - Each base may sit anywhere in the memory independently.
// - Sleep retention keeps stored bytes but loses pointer locations.
// - Read and write commands carry a start offset, zero being first location.
// - Access offset advances automatically after every byte transferred.
// - Received bytes are written even if the packet checksum fails.
// - Received packets are not bounded and may run into transmit area.
// - Host reaches memory only through the serial control port.
`timescale 1ns/1ns
`include "rpdb_regs.svh"
module rpdb_core (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire rpdb_pkg::rpdb_mode_t mode_i,
    input wire logic continuous_rx_i,
    input wire logic set_buffer_bases_cmd_i,
    input wire rpdb_pkg::rpdb_ofs_t cmd_rx_base_i,
    input wire rpdb_pkg::rpdb_ofs_t cmd_tx_base_i,
    input wire rpdb_pkg::rpdb_ofs_t payload_len_i,
    input wire logic access_start_i,
    input wire rpdb_pkg::rpdb_ofs_t access_offset_i,
    input wire logic payload_memory_write_cmd_i,
    input wire logic payload_memory_read_cmd_i,
    input wire rpdb_pkg::rpdb_byte_t host_wdata_i,
    output logic host_ready_o,
    output rpdb_pkg::rpdb_byte_t host_rdata_o,
    output logic host_rvalid_o,
    input wire logic rx_byte_valid_i,
    input wire rpdb_pkg::rpdb_byte_t rx_byte_i,
    input wire logic rx_packet_end_i,
    output logic rx_byte_ready_o,
    input wire logic tx_byte_req_i,
    output rpdb_pkg::rpdb_byte_t tx_byte_o,
    output logic tx_byte_valid_o,
    output logic tx_done_o,
    output rpdb_pkg::rpdb_ofs_t receive_base_offset_o,
    output rpdb_pkg::rpdb_ofs_t transmit_base_offset_o,
    output rpdb_pkg::rpdb_ofs_t receive_write_pointer_o,
    output rpdb_pkg::rpdb_ofs_t transmit_fetch_pointer_o,
    output rpdb_pkg::rpdb_ofs_t received_start_offset_o,
    output rpdb_pkg::rpdb_ofs_t received_byte_count_o,
    rpdb_mem_if.master mem
);
    import rpdb_pkg::*;

    rpdb_ofs_t rx_base_r, rx_base_nxt;
    rpdb_ofs_t tx_base_r, tx_base_nxt;
    rpdb_ofs_t rx_ptr_r, rx_ptr_nxt;
    rpdb_ofs_t tx_ptr_r, tx_ptr_nxt;
    rpdb_ofs_t start_r, start_nxt;
    rpdb_ofs_t count_r, count_nxt;
    rpdb_ofs_t sent_r, sent_nxt;
    rpdb_ofs_t acc_r, acc_nxt;
    logic rx_first_r, rx_first_nxt;
    logic rx_ptr_ok_r, rx_ptr_ok_nxt;
    logic tx_ptr_ok_r, tx_ptr_ok_nxt;
    logic rvalid_r, rvalid_nxt;
    logic tx_rd_r, tx_rd_nxt;
    rpdb_mode_t mode_r;
    logic host_go;
    logic rx_go;
    logic tx_go;
    logic awake;
    logic rx_entry;
    logic tx_entry;
    rpdb_ofs_t rx_slot;
    logic pkt_open_r, pkt_open_nxt;
    rpdb_ofs_t pkt_cnt_r, pkt_cnt_nxt;

    // ==========================================
    // Arbitration of the single memory port
    assign awake = (mode_i != RPDB_MODE_SLEEP);
    assign host_go = awake && (payload_memory_write_cmd_i || payload_memory_read_cmd_i);
    // No radio byte moves on an entry cycle, so a pointer reload never meets a write
    assign rx_go = awake && (mode_i == RPDB_MODE_RX) && rx_byte_valid_i && !host_go
        && !rx_entry;
    assign tx_go = awake && (mode_i == RPDB_MODE_TX) && tx_byte_req_i && !host_go
        && !rx_go && !tx_entry && (sent_r != payload_len_i);
    assign host_ready_o = awake;
    assign rx_byte_ready_o = awake && (mode_i == RPDB_MODE_RX) && !host_go
        && !rx_entry;
    assign rx_entry = (mode_i == RPDB_MODE_RX) && (mode_r != RPDB_MODE_RX);
    assign tx_entry = (mode_i == RPDB_MODE_TX) && (mode_r != RPDB_MODE_TX);
    // Next free receive slot: base on first byte, else one past last written
    assign rx_slot = rx_first_r ? rx_ptr_r : rx_ptr_r + 8'h01;

    // Memory strobes; a host offset from access_start takes effect the same cycle
    always_comb begin
        mem.we = 1'b0;
        mem.addr = acc_r;
        mem.wdata = host_wdata_i;
        if (host_go) begin
            mem.we = payload_memory_write_cmd_i;
            mem.addr = access_start_i ? access_offset_i : acc_r;
        end else if (rx_go) begin
            mem.we = 1'b1; // Checksum is not looked at here
            mem.addr = rx_slot; // No region bound
            mem.wdata = rx_byte_i;
        end else if (tx_go) begin
            mem.addr = tx_ptr_r;
        end
    end

    // ==========================================
    // Next-state of bases, pointers and status
    always_comb begin
        rx_base_nxt = rx_base_r;
        tx_base_nxt = tx_base_r;
        rx_ptr_nxt = rx_ptr_r;
        tx_ptr_nxt = tx_ptr_r;
        start_nxt = start_r;
        count_nxt = count_r;
        sent_nxt = sent_r;
        acc_nxt = acc_r;
        rx_first_nxt = rx_first_r;
        rx_ptr_ok_nxt = rx_ptr_ok_r;
        tx_ptr_ok_nxt = tx_ptr_ok_r;
        rvalid_nxt = host_go && payload_memory_read_cmd_i;
        tx_rd_nxt = tx_go;
        if (set_buffer_bases_cmd_i) begin
            rx_base_nxt = cmd_rx_base_i;
            tx_base_nxt = cmd_tx_base_i;
        end
        if (access_start_i) begin
            acc_nxt = access_offset_i;
        end
        if (host_go) begin
            acc_nxt = mem.addr + 8'h01;
        end
        if (rx_entry && (!continuous_rx_i || !rx_ptr_ok_r)) begin
            rx_ptr_nxt = rx_base_r;
            rx_first_nxt = 1'b1;
            rx_ptr_ok_nxt = 1'b1;
        end else if (rx_go) begin
            rx_ptr_nxt = rx_slot; // Pointer holds last written offset
            rx_first_nxt = 1'b0;
            count_nxt = pkt_cnt_nxt;
            if (count_r == 8'h00 || !pkt_open_r) begin
                start_nxt = rx_slot;
            end
        end
        if (tx_entry) begin
            tx_ptr_nxt = tx_base_r;
            sent_nxt = 8'h00;
            tx_ptr_ok_nxt = 1'b1;
        end else if (tx_go) begin
            tx_ptr_nxt = tx_ptr_r + 8'h01;
            sent_nxt = sent_r + 8'h01;
        end
        if (!awake) begin
            rx_ptr_ok_nxt = 1'b0; // Pointers lost, data kept
            tx_ptr_ok_nxt = 1'b0;
            rx_ptr_nxt = `RPDB_PTR_RST;
            tx_ptr_nxt = `RPDB_PTR_RST;
        end
    end

    // Packet length tracker: counts bytes since the latest packet began
    always_comb begin
        pkt_open_nxt = pkt_open_r;
        pkt_cnt_nxt = pkt_cnt_r;
        if (rx_entry || !awake) begin
            pkt_open_nxt = 1'b0;
        end
        if (rx_go) begin
            pkt_open_nxt = 1'b1;
            pkt_cnt_nxt = pkt_open_r ? pkt_cnt_r + 8'h01 : 8'h01;
        end
        if (rx_packet_end_i) begin
            pkt_open_nxt = 1'b0; // Next byte opens a new packet
        end
    end

    // Status shows only the latest packet
    always_comb begin
        received_start_offset_o = start_r;
        received_byte_count_o = count_r;
    end

    // ==========================================
    // State registers
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rx_base_r <= `RPDB_RX_BASE_RST;
            tx_base_r <= `RPDB_TX_BASE_RST;
            rx_ptr_r <= `RPDB_PTR_RST;
            tx_ptr_r <= `RPDB_PTR_RST;
            start_r <= `RPDB_PTR_RST;
            count_r <= `RPDB_LEN_RST;
            sent_r <= `RPDB_LEN_RST;
            acc_r <= `RPDB_PTR_RST;
            rx_first_r <= 1'b1;
            rx_ptr_ok_r <= 1'b0;
            tx_ptr_ok_r <= 1'b0;
            rvalid_r <= 1'b0;
            tx_rd_r <= 1'b0;
            mode_r <= RPDB_MODE_IDLE;
            pkt_open_r <= 1'b0;
            pkt_cnt_r <= `RPDB_LEN_RST;
        end else begin
            rx_base_r <= rx_base_nxt;
            tx_base_r <= tx_base_nxt;
            rx_ptr_r <= rx_ptr_nxt;
            tx_ptr_r <= tx_ptr_nxt;
            start_r <= start_nxt;
            count_r <= count_nxt;
            sent_r <= sent_nxt;
            acc_r <= acc_nxt;
            rx_first_r <= rx_first_nxt;
            rx_ptr_ok_r <= rx_ptr_ok_nxt;
            tx_ptr_ok_r <= tx_ptr_ok_nxt;
            rvalid_r <= rvalid_nxt;
            tx_rd_r <= tx_rd_nxt;
            mode_r <= mode_i;
            pkt_open_r <= pkt_open_nxt;
            pkt_cnt_r <= pkt_cnt_nxt;
        end
    end

    // Read data comes straight from the memory's registered port
    assign host_rdata_o = mem.rdata;
    assign host_rvalid_o = rvalid_r;
    assign tx_byte_o = mem.rdata;
    assign tx_byte_valid_o = tx_rd_r;
    assign tx_done_o = (mode_i == RPDB_MODE_TX) && (sent_r == payload_len_i);
    assign receive_base_offset_o = rx_base_r;
    assign transmit_base_offset_o = tx_base_r;
    assign receive_write_pointer_o = rx_ptr_r;
    assign transmit_fetch_pointer_o = tx_ptr_r;

    // ==========================================
    // Checks
    chk_tx_entry_load: assert property (@(posedge clk_i) disable iff (reset_i)
        tx_entry && awake |=> transmit_fetch_pointer_o == $past(tx_base_r))
        else $error("fetch pointer not loaded from transmit base");

    chk_tx_stop_count: assert property (@(posedge clk_i) disable iff (reset_i)
        sent_r == payload_len_i |-> !tx_go)
        else $error("fetch beyond payload length");

    chk_rx_single_load: assert property (@(posedge clk_i) disable iff (reset_i)
        rx_entry && !continuous_rx_i && awake |=> receive_write_pointer_o == $past(rx_base_r))
        else $error("receive pointer not reloaded");

    chk_rx_ptr_step: assert property (@(posedge clk_i) disable iff (reset_i)
        rx_go && !rx_first_r && !rx_entry |=> rx_ptr_r == $past(rx_ptr_r) + 8'h01)
        else $error("receive pointer did not step");

    chk_rx_write_crc: assert property (@(posedge clk_i) disable iff (reset_i)
        rx_go |-> mem.we && mem.wdata == rx_byte_i)
        else $error("received byte not written");

    chk_acc_auto_inc: assert property (@(posedge clk_i) disable iff (reset_i)
        host_go && !access_start_i |=> acc_r == $past(acc_r) + 8'h01)
        else $error("access offset did not advance");

    chk_bases_write: assert property (@(posedge clk_i) disable iff (reset_i)
        set_buffer_bases_cmd_i |=> rx_base_r == $past(cmd_rx_base_i)
        && tx_base_r == $past(cmd_tx_base_i))
        else $error("bases not written");

    chk_sleep_no_acc: assert property (@(posedge clk_i) disable iff (reset_i)
        !awake |-> !mem.we ##1 !host_rvalid_o)
        else $error("access while asleep");

    chk_sleep_ptr_lost: assert property (@(posedge clk_i) disable iff (reset_i)
        !awake |=> !rx_ptr_ok_r && !tx_ptr_ok_r)
        else $error("pointers kept through sleep");

    // Host access holds off both radio directions on the shared port
    chk_host_over_radio: assert property (@(posedge clk_i) disable iff (reset_i)
        host_go |-> !rx_byte_ready_o && !rx_go && !tx_go)
        else $error("radio access during host access");
    chk_rx_start_latch: assert property (@(posedge clk_i) disable iff (reset_i)
        rx_go && !pkt_open_r |=> received_start_offset_o == $past(rx_slot))
        else $error("packet start offset not latched");
    chk_sleep_ptr_zero: assert property (@(posedge clk_i) disable iff (reset_i)
        !awake |=> receive_write_pointer_o == 8'h00 && transmit_fetch_pointer_o == 8'h00)
        else $error("pointers not cleared in sleep");

    // Scenarios worth seeing
    cov_rx_cont_keep: cover property (@(posedge clk_i) disable iff (reset_i)
        rx_entry && continuous_rx_i && rx_ptr_ok_r);
    cov_rx_packet: cover property (@(posedge clk_i) disable iff (reset_i)
        rx_go ##1 rx_go ##1 rx_packet_end_i);
    cov_tx_done: cover property (@(posedge clk_i) disable iff (reset_i)
        tx_go ##1 tx_done_o);
    cov_host_read: cover property (@(posedge clk_i) disable iff (reset_i)
        access_start_i && payload_memory_read_cmd_i ##1 host_rvalid_o);
    cov_rx_wrap: cover property (@(posedge clk_i) disable iff (reset_i)
        rx_go && rx_ptr_r == 8'hff && !rx_first_r);
endmodule

// File: rpdb_regs.svh
// Purpose: Constants for the radio packet data buffer.
// Assumes: Offsets and pointers are eight bits wide.
// Notes: Definitions only.
`ifndef RPDB_REGS_SVH
`define RPDB_REGS_SVH
// ==========================================
// Reset values and sizes
`define RPDB_DEPTH 256
`define RPDB_RX_BASE_RST 8'h00
`define RPDB_TX_BASE_RST 8'h00
`define RPDB_PTR_RST 8'h00
`define RPDB_LEN_RST 8'h00
`endif

// File: rpdb_pkg.sv
// Purpose: Types shared by the radio packet data buffer modules.
// Assumes: Eight-bit offsets.
// Notes: Constants live in rpdb_regs.svh.
package rpdb_pkg;
    typedef logic [7:0] rpdb_byte_t;
    typedef logic [7:0] rpdb_ofs_t;
    typedef enum logic [1:0] {
        RPDB_MODE_IDLE,
        RPDB_MODE_RX,
        RPDB_MODE_TX,
        RPDB_MODE_SLEEP
    } rpdb_mode_t;
endpackage

// File: rpdb_mem_if.sv
// Purpose: Carries one memory port between the buffer modules.
// Assumes: One access per cycle, read data one cycle later.
// Notes: Master drives strobes, memory answers.
`timescale 1ns/1ns
interface rpdb_mem_if;
    import rpdb_pkg::*;
    logic we;
    rpdb_ofs_t addr;
    rpdb_byte_t wdata;
    rpdb_byte_t rdata;
    modport master (output we, output addr, output wdata, input rdata);
    modport memory (input we, input addr, input wdata, output rdata);
endinterface

// File: rpdb_ram.sv
// Purpose: 256-byte payload store with a registered read port.
// Assumes: Contents survive sleep; no reset on the array.
// Notes: Uninitialised at power up.
`timescale 1ns/1ns
`include "rpdb_regs.svh"
module rpdb_ram (
    input wire logic clk_i,
    rpdb_mem_if.memory mem
);
    import rpdb_pkg::*;
    rpdb_byte_t store [0:`RPDB_DEPTH-1];
    rpdb_byte_t rdata_r;
    // ==========================================
    // Array port; no reset so retention holds data
    always_ff @(posedge clk_i) begin
        if (mem.we) begin
            store[mem.addr] <= mem.wdata;
        end
        rdata_r <= store[mem.addr];
    end
    assign mem.rdata = rdata_r;
endmodule

// File: rpdb_top.sv
// Purpose: Top of the radio packet data buffer: core plus payload memory.
// Assumes: All inputs synchronous to clk_i.
// Notes: Plain ports only.
`timescale 1ns/1ns
module rpdb_top (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire rpdb_pkg::rpdb_mode_t mode_i,
    input wire logic continuous_rx_i,
    input wire logic set_buffer_bases_cmd_i,
    input wire rpdb_pkg::rpdb_ofs_t cmd_rx_base_i,
    input wire rpdb_pkg::rpdb_ofs_t cmd_tx_base_i,
    input wire rpdb_pkg::rpdb_ofs_t payload_len_i,
    input wire logic access_start_i,
    input wire rpdb_pkg::rpdb_ofs_t access_offset_i,
    input wire logic payload_memory_write_cmd_i,
    input wire logic payload_memory_read_cmd_i,
    input wire rpdb_pkg::rpdb_byte_t host_wdata_i,
    output logic host_ready_o,
    output rpdb_pkg::rpdb_byte_t host_rdata_o,
    output logic host_rvalid_o,
    input wire logic rx_byte_valid_i,
    input wire rpdb_pkg::rpdb_byte_t rx_byte_i,
    input wire logic rx_packet_end_i,
    output logic rx_byte_ready_o,
    input wire logic tx_byte_req_i,
    output rpdb_pkg::rpdb_byte_t tx_byte_o,
    output logic tx_byte_valid_o,
    output logic tx_done_o,
    output rpdb_pkg::rpdb_ofs_t receive_base_offset_o,
    output rpdb_pkg::rpdb_ofs_t transmit_base_offset_o,
    output rpdb_pkg::rpdb_ofs_t receive_write_pointer_o,
    output rpdb_pkg::rpdb_ofs_t transmit_fetch_pointer_o,
    output rpdb_pkg::rpdb_ofs_t received_start_offset_o,
    output rpdb_pkg::rpdb_ofs_t received_byte_count_o
);
    import rpdb_pkg::*;
    // ==========================================
    // Core and memory joined by one port
    rpdb_mem_if mem_bus ();
    rpdb_core u_core (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .mode_i(mode_i),
        .continuous_rx_i(continuous_rx_i),
        .set_buffer_bases_cmd_i(set_buffer_bases_cmd_i),
        .cmd_rx_base_i(cmd_rx_base_i),
        .cmd_tx_base_i(cmd_tx_base_i),
        .payload_len_i(payload_len_i),
        .access_start_i(access_start_i),
        .access_offset_i(access_offset_i),
        .payload_memory_write_cmd_i(payload_memory_write_cmd_i),
        .payload_memory_read_cmd_i(payload_memory_read_cmd_i),
        .host_wdata_i(host_wdata_i),
        .host_ready_o(host_ready_o),
        .host_rdata_o(host_rdata_o),
        .host_rvalid_o(host_rvalid_o),
        .rx_byte_valid_i(rx_byte_valid_i),
        .rx_byte_i(rx_byte_i),
        .rx_packet_end_i(rx_packet_end_i),
        .rx_byte_ready_o(rx_byte_ready_o),
        .tx_byte_req_i(tx_byte_req_i),
        .tx_byte_o(tx_byte_o),
        .tx_byte_valid_o(tx_byte_valid_o),
        .tx_done_o(tx_done_o),
        .receive_base_offset_o(receive_base_offset_o),
        .transmit_base_offset_o(transmit_base_offset_o),
        .receive_write_pointer_o(receive_write_pointer_o),
        .transmit_fetch_pointer_o(transmit_fetch_pointer_o),
        .received_start_offset_o(received_start_offset_o),
        .received_byte_count_o(received_byte_count_o),
        .mem(mem_bus.master)
    );
    rpdb_ram u_ram (
        .clk_i(clk_i),
        .mem(mem_bus.memory)
    );
endmodule

// File: rpdb_host_model.sv
// Purpose: Host-side model that fills and drains the payload memory.
// Assumes: Commands change 1 ns after the rising clock edge.
// Notes: Released data and offset lines show inverted values, never the last ones.
`timescale 1ns/1ns
module rpdb_host_model (
    input wire logic clk_i,
    input wire rpdb_pkg::rpdb_byte_t host_rdata_i,
    input wire logic host_rvalid_i,
    output logic access_start_o,
    output rpdb_pkg::rpdb_ofs_t access_offset_o,
    output logic payload_memory_write_cmd_o,
    output logic payload_memory_read_cmd_o,
    output rpdb_pkg::rpdb_byte_t host_wdata_o
);
    import rpdb_pkg::*;
    // ==========================================
    // Idle levels at time zero
    initial begin
        access_start_o = 1'b0;
        access_offset_o = 8'h5a;
        payload_memory_write_cmd_o = 1'b0;
        payload_memory_read_cmd_o = 1'b0;
        host_wdata_o = 8'ha5;
    end
    // ==========================================
    // Burst write, start offset given with the first byte
    task automatic write_bytes(input rpdb_ofs_t ofs, input rpdb_byte_t d[$]);
        foreach (d[i]) begin
            @(posedge clk_i);
            #1;
            access_start_o = (i == 0);
            access_offset_o = ofs;
            payload_memory_write_cmd_o = 1'b1;
            host_wdata_o = d[i];
        end
        @(posedge clk_i);
        #1;
        access_start_o = 1'b0;
        payload_memory_write_cmd_o = 1'b0;
        host_wdata_o = ~host_wdata_o; // Released lines must not look valid
        access_offset_o = ~ofs;
    endtask
    // ==========================================
    // Burst read; each answer is taken one cycle after its request
    task automatic read_bytes(input rpdb_ofs_t ofs, input int n, ref rpdb_byte_t q[$]);
        q = {};
        for (int i = 0; i <= n; i++) begin
            @(posedge clk_i);
            #1;
            if (host_rvalid_i === 1'b1) begin
                q.push_back(host_rdata_i);
            end
            access_start_o = (i == 0);
            access_offset_o = (i < n) ? ofs : ~ofs;
            payload_memory_read_cmd_o = (i < n);
        end
    endtask
endmodule

// File: tb_top.sv
// Purpose: Self-checking bench for the radio packet data buffer.
// Assumes: Inputs change 1 ns after the rising edge; 50 MHz clock.
// Notes: Expected bytes are built from the write patterns, never read from the block.
`timescale 1ns/1ns
module tb_top;
    import rpdb_pkg::*;
    logic clk_i, reset_i, continuous_rx_i, set_buffer_bases_cmd_i;
    rpdb_mode_t mode_i;
    rpdb_ofs_t cmd_rx_base_i, cmd_tx_base_i, payload_len_i, access_offset_i;
    logic access_start_i, payload_memory_write_cmd_i, payload_memory_read_cmd_i;
    rpdb_byte_t host_wdata_i, host_rdata_o, rx_byte_i, tx_byte_o;
    logic host_ready_o, host_rvalid_o, rx_byte_valid_i, rx_packet_end_i, rx_byte_ready_o;
    logic tx_byte_req_i, tx_byte_valid_o, tx_done_o;
    rpdb_ofs_t rx_base_o, tx_base_o, rx_ptr_o, tx_ptr_o, rx_start_o, rx_count_o;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    rpdb_byte_t q[$];
    rpdb_top i_dut (.clk_i(clk_i), .reset_i(reset_i), .mode_i(mode_i),
        .continuous_rx_i(continuous_rx_i), .set_buffer_bases_cmd_i(set_buffer_bases_cmd_i),
        .cmd_rx_base_i(cmd_rx_base_i), .cmd_tx_base_i(cmd_tx_base_i),
        .payload_len_i(payload_len_i), .access_start_i(access_start_i),
        .access_offset_i(access_offset_i), .payload_memory_write_cmd_i(payload_memory_write_cmd_i),
        .payload_memory_read_cmd_i(payload_memory_read_cmd_i), .host_wdata_i(host_wdata_i),
        .host_ready_o(host_ready_o), .host_rdata_o(host_rdata_o), .host_rvalid_o(host_rvalid_o),
        .rx_byte_valid_i(rx_byte_valid_i), .rx_byte_i(rx_byte_i),
        .rx_packet_end_i(rx_packet_end_i), .rx_byte_ready_o(rx_byte_ready_o),
        .tx_byte_req_i(tx_byte_req_i), .tx_byte_o(tx_byte_o), .tx_byte_valid_o(tx_byte_valid_o),
        .tx_done_o(tx_done_o), .receive_base_offset_o(rx_base_o),
        .transmit_base_offset_o(tx_base_o), .receive_write_pointer_o(rx_ptr_o),
        .transmit_fetch_pointer_o(tx_ptr_o), .received_start_offset_o(rx_start_o),
        .received_byte_count_o(rx_count_o));
    rpdb_host_model i_host (.clk_i(clk_i), .host_rdata_i(host_rdata_o),
        .host_rvalid_i(host_rvalid_o), .access_start_o(access_start_i),
        .access_offset_o(access_offset_i), .payload_memory_write_cmd_o(payload_memory_write_cmd_i),
        .payload_memory_read_cmd_o(payload_memory_read_cmd_i), .host_wdata_o(host_wdata_i));
    // ==========================================
    // Clock and hang guard; the ceiling is about thirty times the expected run
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            summarize();
        end
    end
    // ==========================================
    // Shared helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step(input rpdb_mode_t m);
        @(posedge clk_i);
        #1;
        mode_i = m;
        @(posedge clk_i);
        #1;
    endtask
    // Bytes go out one per accepted cycle, then an end-of-packet pulse
    task automatic rx_packet(input int n, input rpdb_byte_t first);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            #1;
            rx_byte_valid_i = 1'b1;
            rx_byte_i = first + 8'(i);
            while (rx_byte_ready_o !== 1'b1) begin
                @(posedge clk_i);
                #1;
            end
        end
        @(posedge clk_i);
        #1;
        rx_byte_valid_i = 1'b0;
        rx_byte_i = ~rx_byte_i;
        rx_packet_end_i = 1'b1;
        @(posedge clk_i);
        #1;
        rx_packet_end_i = 1'b0;
    endtask
    task automatic read_chk(input rpdb_ofs_t ofs, input int n, input rpdb_byte_t first);
        i_host.read_bytes(ofs, n, q);
        chk(8'(q.size()), 8'(n));
        foreach (q[i]) chk(q[i], first + 8'(i));
    endtask
    // ==========================================
    // Scenarios
    task automatic t_defaults();
        chk(8'(rx_byte_ready_o), 8'h00);
        chk(rx_base_o, 8'h00);
        chk(tx_base_o, 8'h00);
        chk(rx_ptr_o, 8'h00);
        chk(8'(host_ready_o), 8'h01);
    endtask
    task automatic t_host_wrap();
        i_host.write_bytes(8'hfe, '{8'h11, 8'h12, 8'h13, 8'h14});
        read_chk(8'hfe, 4, 8'h11);
        read_chk(8'h00, 1, 8'h13);
    endtask
    task automatic t_bases();
        @(posedge clk_i);
        #1;
        set_buffer_bases_cmd_i = 1'b1;
        cmd_rx_base_i = 8'hf0;
        cmd_tx_base_i = 8'h02;
        @(posedge clk_i);
        #1;
        set_buffer_bases_cmd_i = 1'b0;
        cmd_rx_base_i = 8'h0f;
        cmd_tx_base_i = 8'hfd;
        chk(rx_base_o, 8'hf0);
        chk(tx_base_o, 8'h02);
    endtask
    // Long packet wraps past the top and runs over the transmit area
    task automatic t_rx_single();
        step(RPDB_MODE_RX);
        chk(8'(rx_byte_ready_o), 8'h01);
        rx_packet(20, 8'ha0);
        chk(rx_start_o, 8'hf0);
        chk(rx_count_o, 8'h14);
        chk(rx_ptr_o, 8'h03);
        step(RPDB_MODE_IDLE);
        read_chk(8'hf0, 20, 8'ha0);
        read_chk(8'h02, 1, 8'hb2);
        step(RPDB_MODE_RX);
        rx_packet(2, 8'hc0);
        chk(rx_start_o, 8'hf0);
        chk(rx_count_o, 8'h02);
        chk(rx_ptr_o, 8'hf1);
        step(RPDB_MODE_IDLE);
    endtask
    task automatic t_rx_cont();
        continuous_rx_i = 1'b1;
        step(RPDB_MODE_RX);
        rx_packet(3, 8'hd0);
        rx_packet(2, 8'hd3);
        chk(rx_start_o, 8'hf5);
        chk(rx_count_o, 8'h02);
        chk(rx_ptr_o, 8'hf6);
        step(RPDB_MODE_IDLE);
        continuous_rx_i = 1'b0;
        read_chk(8'hf2, 5, 8'hd0);
    endtask
    // Two transmit entries; each must restart from the base and stop at the length
    task automatic t_tx();
        int n;
        payload_len_i = 8'h04;
        i_host.write_bytes(8'h02, '{8'h50, 8'h51, 8'h52, 8'h53});
        for (int r = 0; r < 2; r++) begin
            n = 0;
            step(RPDB_MODE_TX);
            tx_byte_req_i = 1'b1;
            repeat (12) begin
                @(posedge clk_i);
                #1;
                if (tx_byte_valid_o === 1'b1) begin
                    chk(tx_byte_o, 8'h50 + 8'(n));
                    n++;
                end
            end
            chk(8'(n), 8'h04);
            chk(8'(tx_done_o), 8'h01);
            chk(tx_ptr_o, 8'h06);
            tx_byte_req_i = 1'b0;
            step(RPDB_MODE_IDLE);
        end
    endtask
    // Sleep refuses host writes, keeps data and forgets pointers
    task automatic t_sleep();
        step(RPDB_MODE_SLEEP);
        chk(8'(host_ready_o), 8'h00);
        i_host.write_bytes(8'h02, '{8'hee});
        chk(rx_ptr_o, 8'h00);
        chk(tx_ptr_o, 8'h00);
        step(RPDB_MODE_IDLE);
        read_chk(8'h02, 4, 8'h50);
    endtask
    task automatic summarize();
        if (num_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        reset_i = 1'b1;
        mode_i = RPDB_MODE_IDLE;
        continuous_rx_i = 1'b0;
        set_buffer_bases_cmd_i = 1'b0;
        cmd_rx_base_i = 8'h00;
        cmd_tx_base_i = 8'h00;
        payload_len_i = 8'h00;
        rx_byte_valid_i = 1'b0;
        rx_byte_i = 8'h00;
        rx_packet_end_i = 1'b0;
        tx_byte_req_i = 1'b0;
        repeat (16) @(posedge clk_i);
        #1;
        reset_i = 1'b0;
        t_defaults();
        t_host_wrap();
        t_bases();
        t_rx_single();
        t_rx_cont();
        t_tx();
        t_sleep();
        summarize();
    end
endmodule
